// ---- bench/cold_fault_asserts.sv ----
// Port checker for the cold fault supervisor.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/100ps
module cold_fault_asserts
   import cold_fault_pkg::*;
#(
   parameter int UNIT_CYCLES = UNIT_CYCLES_DEFAULT
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_code,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_err,
   // Commands
   input wire logic clear_status,
   input wire logic clear_faults,
   input wire logic op_on,
   input wire logic other_fault_off,
   // Status
   input wire logic output_enable,
   input wire logic fault_flag,
   input wire logic latched_off
);
   // Shadow of the response register, so checks know the mode
   logic [7:0] act;
   logic [1:0] resp;
   logic mapped;
   assign resp = act[7:6];
   assign mapped = reg_code == CODE_THRESHOLD || reg_code == CODE_ACTION;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   always_ff @(posedge clk)
      if (rst)
         act <= ACTION_RESET;
      else if (reg_wr && reg_code == CODE_ACTION)
         act <= reg_wdata[7:0];
   property p_ack;
      reg_wr || reg_rd |=> reg_ack && reg_err == !$past(mapped);
   endproperty
   a_ack: assert property (p_ack) else $error("bad ack");
   property p_rd;
      reg_wr && reg_code == CODE_THRESHOLD ##3 reg_rd && !reg_wr && reg_code == CODE_THRESHOLD
         |=> reg_rdata == $past(reg_wdata, 4);
   endproperty
   a_rd: assert property (p_rd) else $error("bad read");
   property p_ign;
      resp == RESP_IGNORE && output_enable && op_on && !other_fault_off |=> output_enable;
   endproperty
   a_ign: assert property (p_ign) else $error("dropped");
   property p_dly;
      $rose(fault_flag) && resp == RESP_DELAYED && output_enable |=> output_enable [*3];
   endproperty
   a_dly: assert property (p_dly) else $error("early off");
   property p_dis;
      $rose(fault_flag) && resp[1] |=> !output_enable;
   endproperty
   a_dis: assert property (p_dis) else $error("not off");
   // Clears may land a cycle late, so the cycle after one is exempt
   property p_hold;
      latched_off && op_on && $past(op_on) && !(clear_status || clear_faults || $past(clear_status)
         || $past(clear_faults)) |=> latched_off;
   endproperty
   a_hold: assert property (p_hold) else $error("latch lost");
   property p_none;
      $rose(fault_flag) && resp == RESP_DISABLE && act[5:3] == RETRY_NONE |=> !output_enable [*8];
   endproperty
   a_none: assert property (p_none) else $error("restarted");
   property p_off;
      latched_off |-> !output_enable;
   endproperty
   a_off: assert property (p_off) else $error("on latched");
   c_latch: cover property ($rose(latched_off));
   c_err: cover property (reg_ack && reg_err);
   c_dly: cover property ($rose(fault_flag) && resp == RESP_DELAYED);
endmodule

bind cold_fault_supervisor cold_fault_asserts #(.UNIT_CYCLES(UNIT_CYCLES)) cold_fault_asserts_i (.clk, .rst,
   .reg_wr, .reg_rd, .reg_code, .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .clear_status, .clear_faults,
   .op_on, .other_fault_off, .output_enable, .fault_flag, .latched_off);

// ---- bench/pmbus_host.sv ----
// Host model: one register command at a time.
// Assumes one-cycle strobes and an ack one cycle later.
`timescale 1ns/100ps
module pmbus_host
(
   // Clock
   input wire logic clk,
   // Command port
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_code = 8'h00,
   output logic [15:0] reg_wdata = 16'h0000,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_err
);
   // Bus scrambled after the strobe so stale data cannot pass
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q,
      output logic [1:0] r);
      @(negedge clk);
      reg_wr = w;
      reg_rd = !w;
      reg_code = c;
      reg_wdata = d;
      // Ack and error are one-cycle pulses, so they are taken in the cycle after the strobe edge
      @(negedge clk);
      q = reg_rdata;
      r = {reg_ack, reg_err};
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_code = ~c;
      reg_wdata = ~d;
      @(negedge clk);
   endtask
endmodule

// ---- bench/under_temp_fault_response_tb.sv ----
// Bench for the cold fault supervisor with a host model.
// Assumes a delay unit of 4 cycles to keep retries short.
`timescale 1ns/100ps
module under_temp_fault_response_tb
   import cold_fault_pkg::*;
();
   localparam int UNIT = 4;
   localparam logic [15:0] COLD = 16'h0005;
   localparam logic [15:0] WARM = 16'h0014;
   typedef struct packed {logic w; logic [7:0] c; logic [15:0] d; logic [1:0] r; logic [15:0] q;} row_type;
   row_type rows [9] = '{'{1'b0, 8'h53, 16'h0000, 2'h2, 16'h0000}, '{1'b0, 8'h54, 16'h0000, 2'h2, 16'h0000},
      '{1'b1, 8'h53, 16'h000A, 2'h2, 16'h0000}, '{1'b0, 8'h53, 16'h0000, 2'h2, 16'h000A},
      '{1'b1, 8'h54, 16'h00C0, 2'h2, 16'h0000}, '{1'b0, 8'h54, 16'h0000, 2'h2, 16'h00C0},
      '{1'b1, 8'h55, 16'hFFFF, 2'h3, 16'h0000}, '{1'b0, 8'h52, 16'h0000, 2'h3, 16'h0000},
      '{1'b0, 8'h53, 16'h0000, 2'h2, 16'h000A}};
   logic clk = 1'b0, rst = 1'b1, clear_status = 1'b0, clear_faults = 1'b0, op_on = 1'b1, ctrl_pin = 1'b1;
   logic other_fault_off = 1'b0, temp_valid = 1'b0;
   logic [15:0] temp_value = WARM;
   logic reg_wr, reg_rd, reg_ack, reg_err, output_enable, fault_flag, latched_off;
   logic [7:0] reg_code;
   logic [15:0] reg_wdata, reg_rdata, q;
   logic [1:0] r;
   int n, k;
   int num_errors = 0;
   int checked = 0;
   cold_fault_supervisor #(.UNIT_CYCLES(UNIT)) cold_fault_supervisor_i (.clk, .rst, .reg_wr, .reg_rd,
      .reg_code, .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .clear_status, .clear_faults, .op_on, .ctrl_pin,
      .other_fault_off, .temp_value, .temp_valid, .output_enable, .fault_flag, .latched_off);
   pmbus_host pmbus_host_i (.clk, .reg_wr, .reg_rd, .reg_code, .reg_wdata, .reg_rdata, .reg_ack, .reg_err);
   always #50 clk = ~clk;
   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic temp(input logic [15:0] v);
      @(negedge clk);
      temp_value = v;
      temp_valid = 1'b1;
      @(negedge clk);
      temp_valid = 1'b0;
   endtask
   task automatic set_act(input logic [7:0] a);
      pmbus_host_i.xfer(1'b1, CODE_ACTION, {8'h00, a}, q, r);
   endtask
   task automatic clr();
      temp(WARM);
      clear_faults = 1'b1;
      tick(1);
      clear_faults = 1'b0;
      tick(8);
   endtask
   // Counts enable rises, one per restart attempt
   task automatic watch(input int c);
      logic prev;
      prev = output_enable;
      n = 0;
      repeat (c)
      begin
         @(negedge clk);
         if (output_enable === 1'b1 && prev !== 1'b1)
            n++;
         prev = output_enable;
      end
   endtask
   // Whole run is near 1000 cycles
   initial
   begin
      #600000;
      num_errors++;
      wrap_up();
   end
   initial
   begin
      tick(16);
      rst = 1'b0;
      tick(8);
      foreach (rows[i])
      begin
         pmbus_host_i.xfer(rows[i].w, rows[i].c, rows[i].d, q, r);
         chk(16'(r), 16'(rows[i].r));
         if (!rows[i].w)
            chk(q, rows[i].q);
      end
      set_act(8'h00);
      temp(COLD);
      tick(20);
      chk(16'({output_enable, fault_flag}), 16'h0003);
      clr();
      chk(16'({output_enable, fault_flag}), 16'h0002);
      for (int i = 0; i < 7; i++)
      begin
         set_act({RESP_DISABLE, 3'(i), 3'h0});
         temp(COLD);
         watch(60);
         chk(16'({output_enable, 4'(n)}), 16'(i));
         clr();
      end
      set_act(8'h49);
      temp(COLD);
      k = 0;
      while (output_enable === 1'b1 && k < 60)
      begin
         tick(1);
         k++;
      end
      chk(16'(k >= 2 * UNIT && k <= 2 * UNIT + 4), 16'h0001);
      watch(40);
      chk(16'({latched_off, 4'(n)}), 16'h0011);
      clr();
      set_act(8'hC0);
      temp(COLD);
      tick(30);
      chk(16'({output_enable, latched_off}), 16'h0001);
      clear_status = 1'b1;
      tick(1);
      clear_status = 1'b0;
      tick(6);
      chk(16'(output_enable), 16'h0000);
      temp(WARM);
      clear_status = 1'b1;
      tick(1);
      clear_status = 1'b0;
      tick(6);
      chk(16'({output_enable, latched_off}), 16'h0002);
      temp(COLD);
      tick(10);
      temp(WARM);
      op_on = 1'b0;
      tick(4);
      op_on = 1'b1;
      tick(8);
      chk(16'({output_enable, latched_off}), 16'h0002);
      // Endless retries four units apart: 8 or 9 starts in 150 cycles
      set_act(8'hBA);
      temp(COLD);
      watch(150);
      chk(16'(n >= 8 && n <= 9), 16'h0001);
      op_on = 1'b0;
      watch(30);
      chk(16'({output_enable, 4'(n)}), 16'h0000);
      op_on = 1'b1;
      tick(4);
      other_fault_off = 1'b1;
      tick(1);
      other_fault_off = 1'b0;
      tick(6);
      chk(16'(latched_off), 16'h0001);
      clr();
      set_act(8'h80);
      #430 ctrl_pin = 1'b0;
      tick(10);
      chk(16'(output_enable), 16'h0000);
      #370 ctrl_pin = 1'b1;
      tick(10);
      chk(16'(output_enable), 16'h0001);
      pmbus_host_i.xfer(1'b1, CODE_THRESHOLD, 16'h1234, q, r);
      rst = 1'b1;
      tick(2);
      chk(16'({output_enable, fault_flag, latched_off}), 16'h0000);
      rst = 1'b0;
      pmbus_host_i.xfer(1'b0, CODE_THRESHOLD, 16'h0000, q, r);
      chk(16'(r), 16'h0002);
      chk(q, THRESHOLD_RESET);
      wrap_up();
   end
endmodule

// ---- logic/cold_fault_pkg.sv ----
// Constants and types for the under-temperature fault supervisor.
// Assumes a 10 MHz core clock; the delay unit is held as a time and converted to cycles here.
package cold_fault_pkg;
   // Command codes of the two registers
   localparam logic [7:0] CODE_THRESHOLD = 8'h53;
   localparam logic [7:0] CODE_ACTION = 8'h54;
   localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
   localparam logic [7:0] ACTION_RESET = 8'h00;
   // Field positions in cold_fault_action
   localparam int RESP_HI = 7;
   localparam int RESP_LO = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DELAY_HI = 2;
   localparam int DELAY_LO = 0;
   // Response and retry codes
   localparam logic [1:0] RESP_IGNORE = 2'h0;
   localparam logic [1:0] RESP_DELAYED = 2'h1;
   localparam logic [1:0] RESP_DISABLE = 2'h2;
   localparam logic [1:0] RESP_LATCH = 2'h3;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_ALWAYS = 3'h7;
   localparam logic [7:0] ONE_UNIT = 8'h01;
   // Linear format: 5-bit signed exponent over 11-bit signed mantissa
   localparam int EXP_HI = 15;
   localparam int EXP_LO = 11;
   localparam int MANT_HI = 10;
   localparam int SCALED_W = 48;
   localparam logic [5:0] EXP_BIAS = 6'h10;
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int DELAY_UNIT_NS = 1000000;
   localparam int UNIT_CYCLES_DEFAULT = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UNIT_CNT_W = 24;
   typedef enum {ST_RUN, ST_DELAY, ST_WAIT, ST_TRY, ST_LATCHED} fault_state_type;
endpackage

// ---- logic/cold_fault_supervisor.sv ----
// Under-temperature fault supervisor: limit and response registers, response state machine.
// Assumes a command front end on the same clock and a control pin from outside this clock.
`timescale 1ns/100ps
module cold_fault_supervisor
   import cold_fault_pkg::*;
#(
   parameter int UNIT_CYCLES = UNIT_CYCLES_DEFAULT
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register command port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_code,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   output logic reg_err,
   // Fault clearing and on/off commands
   input wire logic clear_status,
   input wire logic clear_faults,
   input wire logic op_on,
   input wire logic ctrl_pin,
   input wire logic other_fault_off,
   // Temperature samples
   input wire logic [15:0] temp_value,
   input wire logic temp_valid,
   // Status
   output logic output_enable,
   output logic fault_flag,
   output logic latched_off
);
   logic [15:0] cold_fault_threshold;
   logic [7:0] cold_fault_action;
   logic [7:0] units_left;
   logic [UNIT_CNT_W-1:0] div;
   logic [2:0] ctrl_sync, attempts, next_attempts, retry;
   logic [1:0] resp;
   logic ctrl_on, enable_prev, enable_cmd, restart_req, below;
   logic allowed, next_allowed, timer_load, timer_clear;
   fault_state_type state, next_state;
   temp_cmp_if link ();
   assign link.threshold = cold_fault_threshold;
   assign link.temp = temp_value;
   assign link.temp_valid = temp_valid;
   assign below = link.below;
   assign resp = cold_fault_action[RESP_HI:RESP_LO];
   assign retry = cold_fault_action[RETRY_HI:RETRY_LO];
   linear_below comparator
   (
      .clk(clk),
      .rst(rst),
      .link(link.cmp)
   );
   // Register writes
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cold_fault_threshold <= THRESHOLD_RESET;
         cold_fault_action <= ACTION_RESET;
      end
      else if (reg_wr && reg_code == CODE_THRESHOLD)
      begin
         cold_fault_threshold <= reg_wdata;
      end
      else if (reg_wr && reg_code == CODE_ACTION)
      begin
         cold_fault_action <= reg_wdata[7:0];
      end
   end
   // Register reads and answers; unknown codes get an error pulse
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         reg_rdata <= 16'h0000;
         reg_ack <= 1'b0;
         reg_err <= 1'b0;
      end
      else
      begin
         reg_ack <= reg_wr | reg_rd;
         reg_err <= (reg_wr | reg_rd) && reg_code != CODE_THRESHOLD && reg_code != CODE_ACTION;
         if (reg_rd)
         begin
            reg_rdata <= (reg_code == CODE_THRESHOLD) ? cold_fault_threshold
               : (reg_code == CODE_ACTION) ? {8'h00, cold_fault_action} : 16'h0000;
         end
      end
   end
   // Control pin synchroniser; a change counts once the last two stages agree
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_sync <= 3'h0;
         ctrl_on <= 1'b0;
         enable_prev <= 1'b0;
      end
      else
      begin
         ctrl_sync <= {ctrl_sync[1:0], ctrl_pin};
         if (ctrl_sync[1] == ctrl_sync[2])
         begin
            ctrl_on <= ctrl_sync[2];
         end
         enable_prev <= enable_cmd;
      end
   end
   assign enable_cmd = op_on & ctrl_on;
   // Off command, off-then-on, or a status clear all release the fault
   assign restart_req = !enable_cmd || (enable_cmd && !enable_prev) || clear_status || clear_faults;
   // Response state machine, combinational part
   always_comb
   begin
      next_state = state;
      next_attempts = attempts;
      next_allowed = allowed;
      timer_load = 1'b0;
      timer_clear = 1'b0;
      if (restart_req)
      begin
         next_state = ST_RUN;
         next_attempts = 3'h0;
         next_allowed = 1'b1;
         timer_clear = 1'b1;
      end
      else if (other_fault_off)
      begin
         next_state = ST_LATCHED;
         next_allowed = 1'b0;
         timer_clear = 1'b1;
      end
      else
      begin
         unique case (state)
            ST_RUN:
            begin
               next_allowed = 1'b1;
               if (below && resp == RESP_DELAYED)
               begin
                  next_state = ST_DELAY;
                  timer_load = 1'b1;
               end
               else if (below && resp == RESP_DISABLE)
               begin
                  next_allowed = 1'b0;
                  next_attempts = 3'h0;
                  next_state = (retry == RETRY_NONE) ? ST_LATCHED : ST_WAIT;
                  timer_load = 1'b1;
               end
               else if (below && resp == RESP_LATCH)
               begin
                  next_allowed = 1'b0;
                  next_state = ST_LATCHED;
               end
            end
            ST_DELAY:
            begin
               if (!below)
               begin
                  next_state = ST_RUN;
                  timer_clear = 1'b1;
               end
               else if (units_left == 8'h00)
               begin
                  next_allowed = 1'b0;
                  next_attempts = 3'h0;
                  next_state = (retry == RETRY_NONE) ? ST_LATCHED : ST_WAIT;
                  timer_load = 1'b1;
               end
            end
            ST_WAIT:
            begin
               if (units_left == 8'h00)
               begin
                  next_state = ST_TRY;
                  next_allowed = 1'b1;
                  if (retry != RETRY_ALWAYS)
                  begin
                     next_attempts = attempts + 3'h1;
                  end
               end
            end
            ST_TRY:
            begin
               if (!below)
               begin
                  next_state = ST_RUN;
                  next_attempts = 3'h0;
               end
               else
               begin
                  next_allowed = 1'b0;
                  if (retry != RETRY_ALWAYS && attempts >= retry)
                  begin
                     next_state = ST_LATCHED;
                  end
                  else
                  begin
                     next_state = ST_WAIT;
                     timer_load = 1'b1;
                  end
               end
            end
            ST_LATCHED:
            begin
               next_allowed = 1'b0;
            end
         endcase
      end
   end
   // Response state machine, registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= ST_RUN;
         attempts <= 3'h0;
         allowed <= 1'b1;
      end
      else
      begin
         state <= next_state;
         attempts <= next_attempts;
         allowed <= next_allowed;
      end
   end
   // Delay timer in units of the delay time unit
   always_ff @(posedge clk)
   begin
      if (rst || timer_clear)
      begin
         units_left <= 8'h00;
         div <= '0;
      end
      else if (timer_load)
      begin
         units_left <= ONE_UNIT << cold_fault_action[DELAY_HI:DELAY_LO];
         div <= '0;
      end
      else if (units_left != 8'h00)
      begin
         if (div == UNIT_CNT_W'(UNIT_CYCLES - 1))
         begin
            div <= '0;
            units_left <= units_left - 8'h01;
         end
         else
         begin
            div <= div + UNIT_CNT_W'(1);
         end
      end
   end
   // Outputs; with response 00 the output never drops for this fault
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         output_enable <= 1'b0;
         fault_flag <= 1'b0;
         latched_off <= 1'b0;
      end
      else
      begin
         output_enable <= enable_cmd & allowed;
         latched_off <= (state == ST_LATCHED);
         // A new fault in the clearing cycle wins over the clear
         if (below)
         begin
            fault_flag <= 1'b1;
         end
         else if (clear_status || clear_faults)
         begin
            fault_flag <= 1'b0;
         end
      end
   end
endmodule

// ---- logic/linear_below.sv ----
// Compares a linear-format temperature sample against the linear-format limit.
// Assumes samples arrive as one-cycle valid pulses on the core clock.
`timescale 1ns/100ps
module linear_below
   import cold_fault_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Compare link
   temp_cmp_if.cmp link
);
   // Both operands scaled to a common exponent so unlike exponents compare correctly
   function automatic logic signed [SCALED_W-1:0] scale(input logic [15:0] v);
      logic signed [SCALED_W-1:0] m;
      logic [5:0] sh;
      m = SCALED_W'(signed'(v[MANT_HI:0]));
      sh = 6'({v[EXP_HI], v[EXP_HI:EXP_LO]}) + EXP_BIAS;
      return m <<< sh;
   endfunction

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         link.below <= 1'b0;
      end
      else if (link.temp_valid)
      begin
         link.below <= scale(link.temp) < scale(link.threshold);
      end
   end
endmodule

// ---- logic/temp_cmp_if.sv ----
// Carries threshold, temperature sample and the compare result between supervisor and comparator.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface temp_cmp_if;
   logic [15:0] threshold;
   logic [15:0] temp;
   logic temp_valid;
   logic below;
   modport cmp
   (
      input threshold,
      input temp,
      input temp_valid,
      output below
   );
   modport user
   (
      output threshold,
      output temp,
      output temp_valid,
      input below
   );
endinterface
